// ==== hdl/fer_pkg.sv ====
// Shared constants and carrier types for the fill error recovery block
package fer_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CTRL    = 8'h00; // Enables
  localparam logic [7:0] OFF_STATUS  = 8'h04; // Error status, W1C
  localparam logic [7:0] OFF_ADDR_LO = 8'h08; // Block address [37:6]
  localparam logic [7:0] OFF_ADDR_HI = 8'h0C; // Block address [42:38]
  localparam logic [7:0] OFF_SYND    = 8'h10; // Syndromes qw0, qw1
  localparam logic [7:0] OFF_DATA_CACHE_STATUS = 8'h14; // Data cache status, W1C
  localparam logic [7:0] OFF_PEND    = 8'h18; // Pending posts, W1C
  localparam logic [7:0] OFF_SCRUB   = 8'h1C; // Scrub engine state

  // Control field positions
  localparam int CTRL_CRD_EN  = 0;
  localparam int CTRL_MACHINE_CHECK_EN = 1;
  // Error status field positions
  localparam int ST_I_L2  = 0;
  localparam int ST_I_MEM = 1;
  localparam int ST_D_L2  = 2;
  localparam int ST_D_MEM = 3;
  localparam int ST_PROBE = 4;
  // Pending field positions
  localparam int PD_CRD  = 0;
  localparam int PD_MACHINE_CHECK = 1;

  // Reset values
  localparam logic [1:0]  CTRL_RESET   = 2'h3;
  localparam logic [31:0] READ_UNUSED  = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Physical block address width, bits 42 down to 6
  localparam int BLK_W = 37;

  // Scrub engine states
  typedef enum logic [1:0] {
    FER_IDLE   = 2'b00,
    FER_EVICT  = 2'b01,
    FER_REFILL = 2'b10,
    FER_RETRY  = 2'b11
  } fer_scrub_t;

  // A checked fill quadword from the second-level cache or memory
  typedef struct packed {
    logic             valid;     // One-cycle strobe
    logic             icache;    // Destined for instruction cache
    logic             from_mem;  // Source is memory, else L2
    logic             feeds_load;
    logic             speculative;
    logic [2:0]       qw_idx;    // Faulty quadword within block
    logic [BLK_W-1:0] blk_addr;  // Physical address [42:6]
    logic [7:0]       syn0;      // Octaword quadword 0 syndrome
    logic [7:0]       syn1;      // Octaword quadword 1 syndrome
  } fer_fill_t;

  // A victim or probe extraction with a single-bit error
  typedef struct packed {
    logic             valid;
    logic             probe;     // Probe extraction
    logic             on_miss;   // Victim on data and L2 miss
    logic             on_evict;  // Victim of evict-block instruction
    logic [BLK_W-1:0] blk_addr;
    logic [7:0]       syn0;
    logic [7:0]       syn1;
  } fer_victim_t;

  // Register write strobe from the bus slave
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } fer_regwr_t;

endpackage : fer_pkg

// ==== hdl/fer_axil.sv ====
// AXI4-Lite slave that turns bus traffic into register strobes
`timescale 1ns/1ps
`default_nettype none
module fer_axil (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write address and data
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  // Write response
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  // Read address and data
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // Register side
  output var  fer_pkg::fer_regwr_t regwr,
  output var  logic [7:0]        rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_hit,
  input  wire logic              wr_hit
);

  logic       aw_held;  // Write address captured
  logic       w_held;   // Write data captured
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;

  // Ready only while the slot is empty and no response waits
  always_comb begin
    awready = !aw_held && !bvalid && !regwr.wr;
    wready  = !w_held && !bvalid && !regwr.wr;
    arready = !rvalid;
    rd_addr = araddr;
  end

  // Address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      s_q     <= 4'h0;
    end else if (aw_held && w_held) begin
      // Both halves present, the write retires now
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q    <= wdata;
        s_q    <= wstrb;
      end
    end
  end

  // One-cycle write strobe and the response that follows it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regwr  <= '0;
      bvalid <= 1'b0;
      bresp  <= fer_pkg::RESP_OKAY;
    end else begin
      regwr.wr <= aw_held && w_held;
      if (aw_held && w_held) begin
        regwr.addr <= aw_q;
        regwr.data <= w_q;
        regwr.strb <= s_q;
      end
      if (regwr.wr) begin
        bvalid     <= 1'b1;
        bresp      <= wr_hit ? fer_pkg::RESP_OKAY : fer_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= fer_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_hit ? fer_pkg::RESP_OKAY : fer_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : fer_axil
`default_nettype wire

// ==== hdl/fer_top.sv ====
// Single-bit fill error recovery: status capture, scrub and posting
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fer_top (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]            s_awaddr,
  input  wire logic                  s_awvalid,
  output var  logic                  s_awready,
  input  wire logic [31:0]           s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output var  logic                  s_wready,
  output var  logic [1:0]            s_bresp,
  output var  logic                  s_bvalid,
  input  wire logic                  s_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]            s_araddr,
  input  wire logic                  s_arvalid,
  output var  logic                  s_arready,
  output var  logic [31:0]           s_rdata,
  output var  logic [1:0]            s_rresp,
  output var  logic                  s_rvalid,
  input  wire logic                  s_rready,
  // Checked fill and extraction events
  input  wire fer_pkg::fer_fill_t    fill,
  input  wire fer_pkg::fer_victim_t  victim,
  // Core state
  input  wire logic                  privileged_firmware_mode,
  input  wire logic                  machine_check_withdraw,
  // Load queue scrub handshake
  input  wire logic                  rd_err_req,
  input  wire logic                  evict_done,
  input  wire logic                  refill_done,
  // Instruction cache controls
  output var  logic                  ic_flush,
  output var  logic                  ic_bad_par,
  output var  logic [1:0]            ic_bad_par_ow,
  // Data path controls
  output var  logic                  dc_write_raw,
  output var  logic                  load_wb_raw,
  output var  logic                  lq_hold,
  output var  logic                  replay_trap,
  output var  logic                  map_stall,
  output var  logic                  scrub_evict,
  output var  logic                  scrub_refill,
  output var  logic                  load_retry,
  output var  logic                  fwd_raw,
  // Posted exceptions
  output var  logic                  corrected_read_interrupt,
  output var  logic                  machine_check
);

  // Software enables
  logic [1:0]              ctrl;
  // Error status flags
  logic [4:0]              status;
  // Captured block address, bits 42 down to 6
  logic [fer_pkg::BLK_W-1:0] err_addr;
  // Captured syndromes of the faulty octaword
  logic [7:0]              syndrome0;
  logic [7:0]              syndrome1;
  // Data cache status, load check-code flag only
  logic                    load_check_code_err_flag;
  // Pending posts awaiting firmware
  logic                    crd_pend;
  logic                    machine_check_pend;
  // Scrub engine
  fer_pkg::fer_scrub_t     scrub_state;
  fer_pkg::fer_scrub_t     next_scrub_state;
  // Bus slave hookup
  fer_pkg::fer_regwr_t     regwr;
  logic [7:0]              rd_addr;
  logic [31:0]             rd_data;
  logic                    rd_hit;
  logic                    wr_hit;

  // Event classification
  logic ev_ifill;      // Instruction cache fill error
  logic ev_dfill_use;  // Data fill error feeding a live load
  logic ev_dfill_idle; // Data fill error feeding no load
  logic ev_spec;       // Data fill error on a speculative load
  logic ev_probe;      // Probe extraction error
  logic ev_vic_read;   // Plain or double-miss victim read error
  logic ev_capture;    // Non-speculative fill that latches error information
  logic ev_crd;        // Any event that asks for a corrected-read post
  logic scrub_fin;     // Retry step completes
  logic [4:0] set_st;  // Status flags raised this cycle

  // Byte-lane merge for a register write
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // Address decode shared by read and write
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == fer_pkg::OFF_CTRL)    || (a == fer_pkg::OFF_STATUS)
        || (a == fer_pkg::OFF_ADDR_LO) || (a == fer_pkg::OFF_ADDR_HI)
        || (a == fer_pkg::OFF_SYND)    || (a == fer_pkg::OFF_DATA_CACHE_STATUS)
        || (a == fer_pkg::OFF_PEND)    || (a == fer_pkg::OFF_SCRUB);
  endfunction : is_mapped

  // Write-one-to-clear strobe for a register, set wins elsewhere
  function automatic logic [31:0] w1c(
    input fer_pkg::fer_regwr_t w,
    input logic [7:0]          off
  );
    return (w.wr && w.addr == off) ? lane_merge(32'h0000_0000, w.data,
                                                w.strb) : 32'h0000_0000;
  endfunction : w1c

  // Bus slave
  fer_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_awaddr),
    .awvalid (s_awvalid),
    .awready (s_awready),
    .wdata   (s_wdata),
    .wstrb   (s_wstrb),
    .wvalid  (s_wvalid),
    .wready  (s_wready),
    .bresp   (s_bresp),
    .bvalid  (s_bvalid),
    .bready  (s_bready),
    .araddr  (s_araddr),
    .arvalid (s_arvalid),
    .arready (s_arready),
    .rdata   (s_rdata),
    .rresp   (s_rresp),
    .rvalid  (s_rvalid),
    .rready  (s_rready),
    .regwr   (regwr),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_hit  (rd_hit),
    .wr_hit  (wr_hit)
  );

  // Sort each checked event into its recovery flow
  always_comb begin
    scrub_fin     = scrub_state == fer_pkg::FER_RETRY;
    ev_ifill      = fill.valid && fill.icache;
    ev_spec       = fill.valid && !fill.icache && fill.feeds_load
                    && fill.speculative;
    ev_dfill_use  = fill.valid && !fill.icache && fill.feeds_load
                    && !fill.speculative;
    ev_dfill_idle = fill.valid && !fill.icache && !fill.feeds_load;
    ev_probe      = victim.valid && victim.probe;
    // Evict-block victims are excluded: they post nothing
    ev_vic_read   = victim.valid && !victim.probe && !victim.on_evict;
    ev_capture    = ev_ifill || ev_dfill_use || ev_dfill_idle;
    ev_crd        = ev_ifill || ev_dfill_idle || ev_spec || ev_probe
                    || ev_vic_read || scrub_fin;
    set_st        = '0;
    set_st[fer_pkg::ST_I_L2]  = ev_ifill && !fill.from_mem;
    set_st[fer_pkg::ST_I_MEM] = ev_ifill && fill.from_mem;
    set_st[fer_pkg::ST_D_L2]  = (ev_dfill_use || ev_dfill_idle)
                                && !fill.from_mem;
    set_st[fer_pkg::ST_D_MEM] = (ev_dfill_use || ev_dfill_idle)
                                && fill.from_mem;
    set_st[fer_pkg::ST_PROBE] = ev_probe;
  end

  // Enables; reset leaves both postings on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= fer_pkg::CTRL_RESET;
    end else if (regwr.wr && regwr.addr == fer_pkg::OFF_CTRL) begin
      ctrl <= 2'(lane_merge({30'h0, ctrl}, regwr.data, regwr.strb));
    end
  end

  // Status flags: a new event beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~5'(w1c(regwr, fer_pkg::OFF_STATUS)))
                | set_st;
    end
  end

  // Address and syndromes; speculative and non-probe victim flows leave them, probes load them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_addr  <= '0;
      syndrome0 <= 8'h00;
      syndrome1 <= 8'h00;
    end else if (ev_capture) begin
      err_addr  <= fill.blk_addr;
      syndrome0 <= fill.syn0;
      syndrome1 <= fill.syn1;
    end else if (ev_probe) begin
      err_addr  <= victim.blk_addr;
      syndrome0 <= victim.syn0;
      syndrome1 <= victim.syn1;
    end
  end

  // Load check-code flag, raised when the scrubbed load retries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_check_code_err_flag <= 1'b0;
    end else if (scrub_fin) begin
      load_check_code_err_flag <= 1'b1;
    end else if (1'(w1c(regwr, fer_pkg::OFF_DATA_CACHE_STATUS))) begin
      load_check_code_err_flag <= 1'b0;
    end
  end

  // Corrected-read post; firmware clears it, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crd_pend <= 1'b0;
    end else if (ev_crd && ctrl[fer_pkg::CTRL_CRD_EN]) begin
      crd_pend <= 1'b1;
    end else if (1'(w1c(regwr, fer_pkg::OFF_PEND) >> fer_pkg::PD_CRD)) begin
      crd_pend <= 1'b0;
    end
  end

  // Machine check post; a squashed speculative fill withdraws it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      machine_check_pend <= 1'b0;
    end else if (ev_ifill && ctrl[fer_pkg::CTRL_MACHINE_CHECK_EN]) begin
      machine_check_pend <= 1'b1;
    end else if (machine_check_withdraw || 1'(w1c(regwr, fer_pkg::OFF_PEND)
                 >> fer_pkg::PD_MACHINE_CHECK)) begin
      machine_check_pend <= 1'b0;
    end
  end

  // Exception outputs; the check waits out privileged firmware
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      corrected_read_interrupt <= 1'b0;
      machine_check            <= 1'b0;
    end else begin
      corrected_read_interrupt <= crd_pend;
      machine_check <= machine_check_pend && !privileged_firmware_mode;
    end
  end

  // Instruction fill: poison octaword parity and flush
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ic_flush      <= 1'b0;
      ic_bad_par    <= 1'b0;
      ic_bad_par_ow <= 2'h0;
    end else begin
      ic_flush   <= ev_ifill;
      ic_bad_par <= ev_ifill;
      if (ev_ifill) begin
        // Octaword is the quadword index without its low bit
        ic_bad_par_ow <= fill.qw_idx[2:1];
      end
    end
  end

  // Raw pass-through strobes; no correction on these paths
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dc_write_raw <= 1'b0;
      load_wb_raw  <= 1'b0;
      replay_trap  <= 1'b0;
      fwd_raw      <= 1'b0;
    end else begin
      // Unused quadword goes in with its own check bits
      dc_write_raw <= ev_dfill_idle;
      load_wb_raw  <= ev_dfill_use;
      // Trap point is the load itself, never younger than a consumer
      replay_trap  <= ev_dfill_use;
      // Victims and probes leave uncorrected, evict-block included
      fwd_raw      <= victim.valid;
    end
  end

  // Queue hold and map stall live from detection to retry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lq_hold   <= 1'b0;
      map_stall <= 1'b0;
    end else if (ev_dfill_use) begin
      lq_hold   <= 1'b1;
      map_stall <= 1'b1;
    end else if (scrub_fin) begin
      lq_hold   <= 1'b0;
      map_stall <= 1'b0;
    end
  end

  // Scrub engine next state
  always_comb begin
    next_scrub_state = scrub_state;
    unique case (scrub_state)
      fer_pkg::FER_IDLE: begin
        // Only a held load may start a scrub
        if (rd_err_req && lq_hold) begin
          next_scrub_state = fer_pkg::FER_EVICT;
        end
      end
      fer_pkg::FER_EVICT: begin
        if (evict_done) begin
          next_scrub_state = fer_pkg::FER_REFILL;
        end
      end
      fer_pkg::FER_REFILL: begin
        if (refill_done) begin
          next_scrub_state = fer_pkg::FER_RETRY;
        end
      end
      fer_pkg::FER_RETRY: begin
        next_scrub_state = fer_pkg::FER_IDLE;
      end
    endcase
  end

  // Scrub engine state and its request levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scrub_state  <= fer_pkg::FER_IDLE;
      scrub_evict  <= 1'b0;
      scrub_refill <= 1'b0;
      load_retry   <= 1'b0;
    end else begin
      scrub_state  <= next_scrub_state;
      // Victim buffer eviction cleans the block
      scrub_evict  <= next_scrub_state == fer_pkg::FER_EVICT;
      scrub_refill <= next_scrub_state == fer_pkg::FER_REFILL;
      load_retry   <= next_scrub_state == fer_pkg::FER_RETRY;
    end
  end

  // Register read mux; unmapped addresses read zero with SLVERR
  always_comb begin
    rd_hit  = is_mapped(rd_addr);
    wr_hit  = is_mapped(regwr.addr);
    rd_data = fer_pkg::READ_UNUSED;
    unique case (rd_addr)
      fer_pkg::OFF_CTRL:    rd_data = {30'h0, ctrl};
      fer_pkg::OFF_STATUS:  rd_data = {27'h0, status};
      fer_pkg::OFF_ADDR_LO: rd_data = err_addr[31:0];
      fer_pkg::OFF_ADDR_HI: rd_data = {27'h0, err_addr[36:32]};
      fer_pkg::OFF_SYND:    rd_data = {16'h0, syndrome1, syndrome0};
      fer_pkg::OFF_DATA_CACHE_STATUS: rd_data = {31'h0, load_check_code_err_flag};
      fer_pkg::OFF_PEND:    rd_data = {30'h0, machine_check_pend, crd_pend};
      fer_pkg::OFF_SCRUB:   rd_data = {30'h0, scrub_state};
      default:              rd_data = fer_pkg::READ_UNUSED;
    endcase
  end

endmodule : fer_top
`default_nettype wire

// ==== sim/fer_far_model.sv ====
// Far-side model: fill and victim source, scrub handshake answers
`timescale 1ns/1ps
`default_nettype none
module fer_far_model #(parameter int DLY = 3) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Scrub progress seen from the block
  input  wire logic                 lq_hold,
  input  wire logic                 scrub_evict,
  input  wire logic                 scrub_refill,
  input  wire logic                 load_retry,
  // Events and handshake toward the block
  output var  fer_pkg::fer_fill_t   fill,
  output var  fer_pkg::fer_victim_t victim,
  output var  logic                 rd_err_req,
  output var  logic                 evict_done,
  output var  logic                 refill_done
);
  int cnt; // Cycles spent in the current scrub step
  initial begin
    fill = '0;
    victim = '0;
  end
  // Step timer, so the block sees a slow victim buffer
  always_ff @(posedge aclk) begin
    if (!aresetn || evict_done || refill_done || !(scrub_evict || scrub_refill)) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Ask once per held load; quiet while retrying to avoid a restart
  assign rd_err_req = lq_hold && !scrub_evict && !scrub_refill && !load_retry;
  assign evict_done = scrub_evict && cnt == DLY;
  assign refill_done = scrub_refill && cnt == DLY;
  // One-cycle event strobe, entered just after a rising edge
  task automatic send(input fer_pkg::fer_fill_t f, input fer_pkg::fer_victim_t v);
    fill <= f;
    victim <= v;
    @(posedge aclk);
    fill <= '0;
    victim <= '0;
  endtask : send
endmodule : fer_far_model
`default_nettype wire

// ==== sim/fer_monitor.sv ====
// Checker on the recovery block's event and scrub ports
`timescale 1ns/1ps
`default_nettype none
module fer_monitor (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Events and core state
  input  wire fer_pkg::fer_fill_t   fill,
  input  wire fer_pkg::fer_victim_t victim,
  input  wire logic                 privileged_firmware_mode,
  input  wire logic                 evict_done,
  input  wire logic                 refill_done,
  // Block outputs
  input  wire logic                 ic_flush,
  input  wire logic                 ic_bad_par,
  input  wire logic                 dc_write_raw,
  input  wire logic                 load_wb_raw,
  input  wire logic                 lq_hold,
  input  wire logic                 map_stall,
  input  wire logic                 replay_trap,
  input  wire logic                 scrub_evict,
  input  wire logic                 scrub_refill,
  input  wire logic                 load_retry,
  input  wire logic                 fwd_raw,
  input  wire logic                 corrected_read_interrupt,
  input  wire logic                 machine_check
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic ifl = fill.valid && fill.icache; // Instruction fill error
  wire logic dfl = fill.valid && !fill.icache; // Data fill error
  a_ic_flush: assert property (ifl |=> ic_flush && ic_bad_par)
    else $error("instruction fill did not flush");
  a_ic_posts: assert property (ifl && !privileged_firmware_mode ##1 !privileged_firmware_mode |=> corrected_read_interrupt && machine_check)
    else $error("instruction fill posts missing");
  a_machine_check_defer: assert property (privileged_firmware_mode [*2] |-> !machine_check)
    else $error("machine check in firmware mode");
  a_raw_fill: assert property (dfl && !fill.feeds_load |=> dc_write_raw)
    else $error("unused fill not written raw");
  a_load_trap: assert property (dfl && fill.feeds_load && !fill.speculative |=> load_wb_raw && replay_trap && lq_hold && map_stall)
    else $error("load fill error not trapped");
  a_spec_load: assert property (dfl && fill.speculative |=> !replay_trap ##1 corrected_read_interrupt)
    else $error("speculative load handled wrongly");
  a_victim_raw: assert property (victim.valid |=> fwd_raw)
    else $error("victim not forwarded raw");
  a_evict_quiet: assert property (victim.valid && victim.on_evict && !fill.valid |=> ##1 !$rose(corrected_read_interrupt))
    else $error("evict victim raised interrupt");
  a_scrub_step: assert property (scrub_evict && evict_done |=> scrub_refill && !scrub_evict)
    else $error("scrub did not refill");
  a_load_retry: assert property (scrub_refill && refill_done |=> load_retry ##1 !lq_hold)
    else $error("load not retried");
  c_retry: cover property (load_retry);
  c_ifill: cover property (ifl);
  c_probe: cover property (victim.valid && victim.probe);
endmodule : fer_monitor
`default_nettype wire
bind fer_top fer_monitor i_fer_monitor (.*);

// ==== sim/tb_top.sv ====
// Bench: register bus tasks and event scenarios for the recovery block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [36:0] BA = 37'h1F_2345_6789; // Captured block address
  logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, machine_check_withdraw;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, r, ic_bad_par_ow;
  logic ic_flush, ic_bad_par, dc_write_raw, load_wb_raw, lq_hold, replay_trap;
  logic map_stall, scrub_evict, scrub_refill, load_retry, fwd_raw, machine_check;
  logic corrected_read_interrupt, privileged_firmware_mode;
  logic rd_err_req, evict_done, refill_done;
  fer_pkg::fer_fill_t fill;
  fer_pkg::fer_victim_t victim;
  int err_total = 0, cmp_count = 0, cyc = 0;
  fer_top i_fer_top (.*);
  fer_far_model i_fer_far_model (.*);
  always #2 aclk = ~aclk;
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Bus write; ready sampled mid-cycle, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit pa, pw, pb, ta, tw, tb;
    {pa, pw, pb} = 3'b111;
    s_awaddr <= a; s_wdata <= v; s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
    while (pa || pw || pb) begin
      @(negedge aclk);
      {ta, tw, tb, r} = {s_awready & pa, s_wready & pw, s_bvalid, s_bresp};
      @(posedge aclk);
      if (ta) begin s_awvalid <= 1'b0; pa = 0; end
      if (tw) begin s_wvalid <= 1'b0; pw = 0; end
      if (tb) begin s_bready <= 1'b0; pb = 0; end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bit pa, pr, ta, tr;
    {pa, pr} = 2'b11;
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    while (pa || pr) begin
      @(negedge aclk);
      {ta, tr, d, r} = {s_arready & pa, s_rvalid, s_rdata, s_rresp};
      @(posedge aclk);
      if (ta) begin s_arvalid <= 1'b0; pa = 0; end
      if (tr) begin s_rready <= 1'b0; pr = 0; end
    end
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask : rc
  function automatic fer_pkg::fer_fill_t mkf(input logic [3:0] k);
    mkf = {1'b1, k, 3'h5, BA, 8'hC3, 8'h3C};
  endfunction : mkf
  function automatic fer_pkg::fer_victim_t mkv(input logic [2:0] k);
    mkv = {1'b1, k, BA, 8'hC3, 8'h3C};
  endfunction : mkv
  // One event, wait for any scrub to finish, then check and clear
  task automatic go(input fer_pkg::fer_fill_t f, input fer_pkg::fer_victim_t v,
                    input logic [31:0] est, input logic [1:0] epd);
    int k;
    i_fer_far_model.send(f, v);
    repeat (4) @(posedge aclk);
    for (k = 0; k < 60 && lq_hold !== 1'b0; k++) @(negedge aclk);
    repeat (2) @(posedge aclk);
    chk(k < 60, 1);
    chk({corrected_read_interrupt, machine_check}, {epd[0], epd[1]});
    rc(fer_pkg::OFF_STATUS, est);
    rc(fer_pkg::OFF_PEND, {30'h0, epd});
    rc(fer_pkg::OFF_DATA_CACHE_STATUS, {31'h0, f.feeds_load & ~f.speculative});
    if (est != 0) begin
      rc(fer_pkg::OFF_ADDR_LO, BA[31:0]);
      rc(fer_pkg::OFF_ADDR_HI, {27'h0, BA[36:32]});
      rc(fer_pkg::OFF_SYND, 32'h0000_3CC3);
    end
    wr(fer_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    wr(fer_pkg::OFF_PEND, 32'h3);
    wr(fer_pkg::OFF_DATA_CACHE_STATUS, 32'h1);
  endtask : go
  initial begin
    aclk = 0; aresetn = 0; s_wstrb = 4'hF; machine_check_withdraw = 0;
    {s_awaddr, s_araddr, s_wdata, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    privileged_firmware_mode = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(fer_pkg::OFF_CTRL, 32'h3);
    rc(8'h20, 32'h0);
    chk(r, fer_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0);
    chk(r, fer_pkg::RESP_SLVERR);
    go(mkf(4'h8), '0, 32'h01, 2'h3);
    go(mkf(4'hC), '0, 32'h02, 2'h3);
    go(mkf(4'h0), '0, 32'h04, 2'h1);
    go(mkf(4'h6), '0, 32'h08, 2'h1);
    go(mkf(4'h3), '0, 32'h00, 2'h1);
    go('0, mkv(3'h4), 32'h10, 2'h1);
    go('0, mkv(3'h2), 32'h00, 2'h1);
    go('0, mkv(3'h1), 32'h00, 2'h0);
    go('0, mkv(3'h0), 32'h00, 2'h1);
    privileged_firmware_mode <= 1'b1;
    i_fer_far_model.send(mkf(4'h8), '0);
    repeat (4) @(posedge aclk);
    chk({ic_bad_par_ow, machine_check}, 3'h4);
    privileged_firmware_mode <= 1'b0;
    go('0, '0, 32'h01, 2'h3);
    wr(fer_pkg::OFF_CTRL, 32'h0);
    go('0, mkv(3'h4), 32'h10, 2'h0);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
